// *** gas_reading_uart_uploader.sv ***
// Purpose: sends a five byte reading frame once per second on a serial line
// Assumes: reading and fault inputs come from logic on clk_i
// Notes:   8N1 framing, least significant bit first
// Summary of operation
// - line runs 4800 baud, eight data bits, one stop, no parity.
// - frames are sent unasked, once every second.
// - frame is header AA, status, concentration high, low, checksum.
// - checksum is the low eight bits of the first four bytes summed.
// - status 80 normal, 81 circuit fault, 82 warming up.
// - concentration bytes are zero during warm-up.
// - over-range concentration is sent as all ones.
// - warm-up lasts about thirty seconds after power-on, then normal.
// - frames go out every second from power-on, warm-up included.
`timescale 1ns/1ns
`include "gas_uploader_defs.svh"
module gas_reading_uart_uploader #(
  parameter int FRAME_CYCLES = `FRAME_CYCLES,
  parameter int BIT_CYCLES   = `BIT_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] conc_i,
  input  wire logic        over_range_i,
  input  wire logic        fault_i,
  output logic             txd_o,
  output logic             warming_o
);
  // ----------------------------------------------------------------
  // frame timing and warm-up
  // ----------------------------------------------------------------
  logic [31:0] period_cnt;
  logic [5:0]  warm_cnt;
  logic        tick;
  logic        warm;
  assign tick = (period_cnt == 32'(FRAME_CYCLES - 1));
  assign warm = (warm_cnt != 6'(`WARMUP_FRAMES));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      period_cnt <= 32'h0000_0000;
      warm_cnt   <= 6'h00;
    end else begin
      period_cnt <= tick ? 32'h0000_0000 : period_cnt + 32'h0000_0001;
      if (tick && warm)
        warm_cnt <= warm_cnt + 6'h01;
    end
  end
  assign warming_o = warm;
  // ----------------------------------------------------------------
  // frame content
  // ----------------------------------------------------------------
  gas_uploader_pkg::frame_body_t body;
  logic [15:0] conc_sel;
  logic [7:0]  csum;
  assign conc_sel = warm ? 16'h0000 : (over_range_i ? `CONC_OVER : conc_i);
  assign body.status  = warm ? `STAT_WARMUP : (fault_i ? `STAT_FAULT : `STAT_NORMAL);
  assign body.conc_hi = conc_sel[15:8];
  assign body.conc_lo = conc_sel[7:0];
  assign csum = 8'(`HEADER_BYTE + body.status + body.conc_hi + body.conc_lo);
  logic [39:0] frame_sr;
  logic [2:0]  bytes_left;
  // ----------------------------------------------------------------
  // serial transmitter
  // ----------------------------------------------------------------
  gas_uploader_pkg::tx_state_t state;
  logic [15:0] baud_cnt;
  logic [2:0]  bit_idx;
  logic        baud_end;
  assign baud_end = (baud_cnt == 16'(BIT_CYCLES - 1));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state      <= gas_uploader_pkg::TX_IDLE;
      baud_cnt   <= 16'h0000;
      bit_idx    <= 3'h0;
      frame_sr   <= 40'h00_0000_0000;
      bytes_left <= 3'h0;
      txd_o      <= 1'b1;
    end else begin
      baud_cnt <= (state == gas_uploader_pkg::TX_IDLE || baud_end) ? 16'h0000 : baud_cnt + 16'h0001;
      if (tick) begin
        frame_sr   <= {`HEADER_BYTE, body, csum};
        bytes_left <= 3'(`FRAME_BYTES);
      end
      unique case (state)
        gas_uploader_pkg::TX_IDLE: begin
          txd_o <= 1'b1;
          if (bytes_left != 3'h0 && !tick) begin
            state <= gas_uploader_pkg::TX_START;
            txd_o <= 1'b0;
          end
        end
        gas_uploader_pkg::TX_START: begin
          if (baud_end) begin
            state   <= gas_uploader_pkg::TX_DATA;
            bit_idx <= 3'h0;
            txd_o   <= frame_sr[32];
          end
        end
        gas_uploader_pkg::TX_DATA: begin
          if (baud_end) begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) begin
              state <= gas_uploader_pkg::TX_STOP;
              txd_o <= 1'b1;
            end else begin
              txd_o <= frame_sr[6'(33) + 6'(bit_idx)];
            end
          end
        end
        gas_uploader_pkg::TX_STOP: begin
          if (baud_end) begin
            state <= gas_uploader_pkg::TX_IDLE;
            if (!tick) begin
              frame_sr   <= {frame_sr[31:0], 8'h00};
              bytes_left <= bytes_left - 3'h1;
            end
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence start_bit_s;
    state == gas_uploader_pkg::TX_IDLE ##1 state == gas_uploader_pkg::TX_START;
  endsequence
  start_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    start_bit_s |-> !txd_o) else $error("start bit not low");
  stop_high_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == gas_uploader_pkg::TX_STOP |-> txd_o) else $error("stop bit not high");
  idle_high_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(state == gas_uploader_pkg::TX_IDLE) |-> txd_o) else $error("idle line not high");
  frame_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick |=> bytes_left == 3'(`FRAME_BYTES) && frame_sr[39:32] == `HEADER_BYTE) else $error("frame not loaded");
  csum_ok_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick |=> frame_sr[7:0] == 8'($past(body.status) + $past(body.conc_hi) + $past(body.conc_lo) + 8'hAA))
    else $error("bad checksum");
  warm_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    warm |-> body.status == 8'h82) else $error("warm-up status wrong");
  warm_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    warm |-> conc_sel == 16'h0000) else $error("warm-up concentration not zero");
  over_ones_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!warm && over_range_i) |-> conc_sel == 16'hFFFF) else $error("over-range not all ones");
  warm_end_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !warm |=> !warm) else $error("warm-up reentered");
  period_wrap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick |=> period_cnt == 32'h0000_0000) else $error("period not restarted");
  // ----------------------------------------------------------------
  // frame pacing checks
  // ----------------------------------------------------------------
  // a tick on an idle line must launch a start bit two edges later
  sequence tick_idle_s;
    tick && state == gas_uploader_pkg::TX_IDLE;
  endsequence
  sequence start_launch_s;
    ##2 (state == gas_uploader_pkg::TX_START && !txd_o);
  endsequence
  tick_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick_idle_s |-> start_launch_s)
    else $error("no start bit after frame tick");
  period_bound_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    period_cnt < 32'(FRAME_CYCLES))
    else $error("period counter out of range");
  warm_bound_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    warm_cnt <= 6'(`WARMUP_FRAMES))
    else $error("warm-up counter out of range");
  warm_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tick && warm) |=> warm_cnt == $past(warm_cnt) + 6'h01)
    else $error("warm-up counter did not advance");
  warm_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !tick |=> $stable(warm_cnt))
    else $error("warm-up counter moved between ticks");
  // ----------------------------------------------------------------
  // frame content checks
  // ----------------------------------------------------------------
  fault_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!warm && fault_i) |-> body.status == 8'h81)
    else $error("fault status wrong");
  normal_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!warm && !fault_i) |-> body.status == 8'h80)
    else $error("normal status wrong");
  conc_pass_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!warm && !over_range_i) |-> conc_sel == conc_i)
    else $error("concentration not passed through");
  frame_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick |=> frame_sr[31:24] == $past(body.status))
    else $error("status byte not loaded");
  frame_conc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick |=> frame_sr[23:8] == $past(conc_sel))
    else $error("concentration bytes not loaded high first");
  header_first_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == gas_uploader_pkg::TX_START && bytes_left == 3'(`FRAME_BYTES)) |-> frame_sr[39:32] == 8'hAA)
    else $error("first byte is not the header");
  bytes_bound_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bytes_left <= 3'(`FRAME_BYTES))
    else $error("byte count out of range");
  byte_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == gas_uploader_pkg::TX_STOP && baud_end && !tick) |=> bytes_left == $past(bytes_left) - 3'h1)
    else $error("byte count not stepped");
  // ----------------------------------------------------------------
  // serial format checks
  // ----------------------------------------------------------------
  sequence stop_done_s;
    state == gas_uploader_pkg::TX_STOP && baud_end;
  endsequence
  stop_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    stop_done_s |=> state == gas_uploader_pkg::TX_IDLE)
    else $error("more than one stop bit");
  start_data_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == gas_uploader_pkg::TX_START && baud_end) |=> state == gas_uploader_pkg::TX_DATA && bit_idx == 3'h0)
    else $error("data did not follow start bit");
  data_stop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == gas_uploader_pkg::TX_DATA && baud_end && bit_idx == 3'h7) |=> state == gas_uploader_pkg::TX_STOP)
    else $error("not eight data bits");
  data_bit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == gas_uploader_pkg::TX_DATA |-> txd_o == frame_sr[6'(32) + 6'(bit_idx)])
    else $error("data bit out of order");
  bit_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    baud_cnt < 16'(BIT_CYCLES))
    else $error("bit time overrun");
  idle_count_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == gas_uploader_pkg::TX_IDLE |-> baud_cnt == 16'h0000)
    else $error("bit timer running while idle");
endmodule

// *** gas_uploader_defs.svh ***
// Purpose: constants for the gas reading serial uploader
// Assumes: 50 MHz module clock
// Notes:   times are given in their own unit, cycle counts derived
`ifndef GAS_UPLOADER_DEFS_SVH
`define GAS_UPLOADER_DEFS_SVH
`define CLK_HZ          50000000
`define BAUD_RATE       4800
`define BIT_CYCLES      (`CLK_HZ / `BAUD_RATE)
`define FRAME_PERIOD_MS 1000
`define FRAME_CYCLES    (`CLK_HZ / 1000 * `FRAME_PERIOD_MS)
`define WARMUP_S        30
`define WARMUP_FRAMES   (`WARMUP_S * 1000 / `FRAME_PERIOD_MS)
`define FRAME_BYTES     5
`define HEADER_BYTE     8'hAA
`define STAT_NORMAL     8'h80
`define STAT_FAULT      8'h81
`define STAT_WARMUP     8'h82
`define CONC_OVER       16'hFFFF
`endif

// *** gas_uploader_pkg.sv ***
// Purpose: types for the gas reading serial uploader
// Assumes: nothing
// Notes:   none
package gas_uploader_pkg;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] conc_hi;
    logic [7:0] conc_lo;
  } frame_body_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
endpackage

// *** host_rx_model.sv ***
// Purpose: host side receiver for the reading frames
// Assumes: line idle high, one clock domain
// Notes:   frames with a bad sum are dropped, not reported
`timescale 1ns/1ns
module host_rx_model #(
  parameter int BIT_CYCLES = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rxd_i,
  output logic [39:0]      frame_o,
  output int               n_good_o
);
  logic [7:0]  b;
  logic [39:0] sh;
  int          idx = 0;
  int          n_good = 0;
  assign n_good_o = n_good;
  always begin
    @(negedge rxd_i);
    repeat (BIT_CYCLES / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_i);
      if (i < 8) b[i] = rxd_i;
    end
    // resync: a bad stop or a lost header restarts the hunt
    if (rxd_i !== 1'b1 || (idx == 0 && b !== 8'haa)) idx = 0;
    else begin
      sh = {sh[31:0], b};
      idx++;
    end
    if (idx == 5) begin
      idx = 0;
      if (sh[7:0] === 8'(sh[39:32] + sh[31:24] + sh[23:16] + sh[15:8])) begin
        frame_o = sh;
        n_good++;
      end
    end
  end
endmodule

// *** gas_reading_uart_uploader_test.sv ***
// Purpose: self-checking bench for the reading uploader
// Assumes: short frame and bit counts for simulation
// Notes:   inputs change just after a received frame
`timescale 1ns/1ns
module gas_reading_uart_uploader_test;
  localparam int FC = 2000;
  localparam int BC = 8;
  logic        clk_i = 0, rstn_i = 0, over_range_i = 0, fault_i = 0, txd_o, warming_o;
  logic [15:0] conc_i = 16'h01f4;
  logic [39:0] frame;
  int          n_good, error_cnt = 0, n_compared = 0;
  time         t_last = 0;
  always #10 clk_i = ~clk_i;
  gas_reading_uart_uploader #(.FRAME_CYCLES(FC), .BIT_CYCLES(BC)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
    .conc_i(conc_i), .over_range_i(over_range_i), .fault_i(fault_i), .txd_o(txd_o), .warming_o(warming_o));
  host_rx_model #(.BIT_CYCLES(BC)) host (.clk_i(clk_i), .rxd_i(txd_o), .frame_o(frame), .n_good_o(n_good));
  task automatic check_frame(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t frame got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_period(input time got, input time exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t period got %0t expected %0t", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic next_frame(input logic [7:0] st, input logic [15:0] c);
    int n;
    n = n_good;
    for (int i = 0; i < 2 * FC && n_good == n; i++) @(negedge clk_i);
    check_flag(1'(n_good == n + 1), 1'b1);
    if (t_last != 0) check_period($time - t_last, 64'(FC * 20));
    t_last = $time;
    check_frame(frame, {8'haa, st, c, 8'(8'haa + st + c[15:8] + c[7:0])});
    @(posedge clk_i);
  endtask
  task automatic warm_up_test;
    for (int k = 0; k < 30; k++) begin
      if (k == 20) {fault_i, over_range_i} <= 2'b11;
      next_frame(8'h82, 16'h0000);
      check_flag(warming_o, 1'(k != 29));
    end
    {fault_i, over_range_i} <= 2'b00;
    $display("warm-up test done");
  endtask
  task automatic normal_test;
    next_frame(8'h80, 16'h01f4);
    check_flag(warming_o, 1'b0);
    fault_i <= 1'b1;
    next_frame(8'h81, 16'h01f4);
    {fault_i, over_range_i} <= 2'b01;
    next_frame(8'h80, 16'hffff);
    fault_i <= 1'b1;
    next_frame(8'h81, 16'hffff);
    $display("normal test done");
  endtask
  task automatic reset_test;
    rstn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    check_flag(warming_o, 1'b1);
    check_flag(txd_o, 1'b1);
    rstn_i <= 1'b1;
    t_last = 0;
    next_frame(8'h82, 16'h0000);
    check_flag(warming_o, 1'b1);
    $display("reset test done");
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    warm_up_test();
    normal_test();
    reset_test();
    print_verdict();
  end
  initial begin
    repeat (40 * FC) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule
